// >>> inc/posted_irq_pkg.sv
// constants, register map and bit layout for the posted interrupt clear registers
// What this block does
// - reading a clear register returns one for every source with a posted interrupt
// - software enable clear: writing zero removes that source's posting only, unless that source fires in the same cycle
// - clearing a bit with nothing posted leaves the controller state unchanged unless that source fires in the same cycle
// - software enable set: writing one posts that source, but irq status records a software post, not a bank event
// - writing one while software enable is clear changes nothing
// - writing zero while software enable is set changes nothing
// - bank0 bits 7..4 are serial bus, sleep timer, SPI and GPIO
// - bank0 bits 3..0 are general timer, touch sensing, analog, supply monitor
// - bank1 bits 7..0 are USB endpoints 3..0, frame start, bus reset, timer two, one
package posted_irq_pkg;

    localparam int unsigned ADDR_W = 10;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned BANK_W = 8;
    localparam int unsigned NUM_SOURCES = 16;
    localparam int unsigned SYNC_STAGES = 2;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CLEAR_BANK0 = 8'hda;
    localparam logic [7:0] IDX_CLEAR_BANK1 = 8'hdb;
    localparam logic [7:0] IDX_CONTROL = 8'he0;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'he1;
    localparam logic [7:0] IDX_IRQ_MASK = 8'he2;

    localparam logic [ADDR_W-1:0] ADDR_CLEAR_BANK0 = {IDX_CLEAR_BANK0, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_CLEAR_BANK1 = {IDX_CLEAR_BANK1, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_CONTROL = {IDX_CONTROL, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'h0};

    // bank0 bit positions
    localparam int unsigned B0_SERIAL = 7;
    localparam int unsigned B0_SLEEP = 6;
    localparam int unsigned B0_SPI = 5;
    localparam int unsigned B0_GPIO = 4;
    localparam int unsigned B0_GENERAL_TIMER = 3;
    localparam int unsigned B0_TOUCH_SENSE = 2;
    localparam int unsigned B0_ANALOG = 1;
    localparam int unsigned B0_SUPPLY_MONITOR = 0;

    // bank1 bit positions
    localparam int unsigned B1_USB_EP3 = 7;
    localparam int unsigned B1_USB_EP2 = 6;
    localparam int unsigned B1_USB_EP1 = 5;
    localparam int unsigned B1_USB_EP0 = 4;
    localparam int unsigned B1_USB_FRAME_START = 3;
    localparam int unsigned B1_USB_BUS_RESET = 2;
    localparam int unsigned B1_TIMER_TWO = 1;
    localparam int unsigned B1_TIMER_ONE = 0;

    // control register field
    localparam int unsigned CTRL_SW_ENABLE_BIT = 0;

    // irq status / mask layout
    localparam int unsigned IRQ_W = 4;
    localparam int unsigned IRQ_BANK0_EVENT = 0;
    localparam int unsigned IRQ_BANK1_EVENT = 1;
    localparam int unsigned IRQ_SW_POST = 2;
    localparam int unsigned IRQ_CLEAR_LOST = 3;

    localparam logic [BANK_W-1:0] RESET_CLEAR_BANK = 8'h00;
    localparam logic RESET_SW_ENABLE = 1'b0;
    localparam logic [IRQ_W-1:0] RESET_IRQ_STATUS = 4'h0;
    localparam logic [IRQ_W-1:0] RESET_IRQ_MASK = 4'h0;
    localparam logic [DATA_W-1:0] READ_UNMAPPED = 32'h0000_0000;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } bus_state_t;

endpackage

// >>> hw/source_event_sync.sv
// two-flop synchroniser and rising edge detector for the source event lines
`timescale 1ns/10ps
`default_nettype none
module source_event_sync #(
    parameter int unsigned WIDTH = 16
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] level_i,
    output logic [WIDTH-1:0] pulse_o
);

    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] synced;
    logic [WIDTH-1:0] synced_prev;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_src
            // meta feeds only the second flop
            always_ff @(posedge clk_sys_i) begin
                if (!rst_n_i) begin
                    meta[g] <= 1'b0;
                    synced[g] <= 1'b0;
                    synced_prev[g] <= 1'b0;
                    pulse_o[g] <= 1'b0;
                end else begin
                    meta[g] <= level_i[g];
                    synced[g] <= meta[g];
                    synced_prev[g] <= synced[g];
                    pulse_o[g] <= synced[g] & ~synced_prev[g];
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

// >>> hw/posted_interrupt_clear_regs.sv
// posted interrupt clear and post registers with avalon-mm slave
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module posted_interrupt_clear_regs (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // avalon-mm slave
    input wire logic [posted_irq_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [posted_irq_pkg::DATA_W-1:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [posted_irq_pkg::DATA_W-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // bank0 source lines
    input wire logic serial_bus_event_i,
    input wire logic sleep_timer_event_i,
    input wire logic spi_event_i,
    input wire logic gpio_event_i,
    input wire logic general_timer_source_i,
    input wire logic touch_sense_source_i,
    input wire logic analog_event_i,
    input wire logic supply_monitor_event_i,
    // bank1 source lines
    input wire logic usb_ep3_event_i,
    input wire logic usb_ep2_event_i,
    input wire logic usb_ep1_event_i,
    input wire logic usb_ep0_event_i,
    input wire logic usb_frame_start_event_i,
    input wire logic usb_bus_reset_event_i,
    input wire logic timer_two_source_i,
    input wire logic timer_one_source_i,
    // state seen by the vector logic
    output logic [posted_irq_pkg::BANK_W-1:0] posted_bank0_o,
    output logic [posted_irq_pkg::BANK_W-1:0] posted_bank1_o,
    output logic software_interrupt_enable_o,
    output logic irq_o
);

    localparam int unsigned BW = posted_irq_pkg::BANK_W;
    localparam int unsigned IW = posted_irq_pkg::IRQ_W;

    posted_irq_pkg::bus_state_t bus_state;
    posted_irq_pkg::bus_state_t next_bus_state;

    logic [BW-1:0] interrupt_clear_bank0;
    logic [BW-1:0] interrupt_clear_bank1;
    logic software_interrupt_enable;
    logic [IW-1:0] irq_status;
    logic [IW-1:0] irq_mask;

    logic [posted_irq_pkg::NUM_SOURCES-1:0] src_level;
    logic [posted_irq_pkg::NUM_SOURCES-1:0] src_pulse;
    logic [BW-1:0] event0;
    logic [BW-1:0] event1;

    logic sel_bank0;
    logic sel_bank1;
    logic sel_control;
    logic sel_irq_status;
    logic sel_irq_mask;
    logic [posted_irq_pkg::DATA_W-1:0] read_value;

    logic taken;
    logic wr_lane0;
    logic [BW-1:0] wbyte;
    logic wr_bank0;
    logic wr_bank1;

    logic [BW-1:0] set0;
    logic [BW-1:0] set1;
    logic [BW-1:0] clr0;
    logic [BW-1:0] clr1;
    logic [BW-1:0] next_bank0;
    logic [BW-1:0] next_bank1;
    logic [IW-1:0] irq_event;
    logic [IW-1:0] next_irq_status;

    // source lines placed at their register bit positions
    always_comb begin
        src_level = '0;
        src_level[posted_irq_pkg::B0_SERIAL] = serial_bus_event_i;
        src_level[posted_irq_pkg::B0_SLEEP] = sleep_timer_event_i;
        src_level[posted_irq_pkg::B0_SPI] = spi_event_i;
        src_level[posted_irq_pkg::B0_GPIO] = gpio_event_i;
        src_level[posted_irq_pkg::B0_GENERAL_TIMER] = general_timer_source_i;
        src_level[posted_irq_pkg::B0_TOUCH_SENSE] = touch_sense_source_i;
        src_level[posted_irq_pkg::B0_ANALOG] = analog_event_i;
        src_level[posted_irq_pkg::B0_SUPPLY_MONITOR] = supply_monitor_event_i;
        src_level[BW + posted_irq_pkg::B1_USB_EP3] = usb_ep3_event_i;
        src_level[BW + posted_irq_pkg::B1_USB_EP2] = usb_ep2_event_i;
        src_level[BW + posted_irq_pkg::B1_USB_EP1] = usb_ep1_event_i;
        src_level[BW + posted_irq_pkg::B1_USB_EP0] = usb_ep0_event_i;
        src_level[BW + posted_irq_pkg::B1_USB_FRAME_START] = usb_frame_start_event_i;
        src_level[BW + posted_irq_pkg::B1_USB_BUS_RESET] = usb_bus_reset_event_i;
        src_level[BW + posted_irq_pkg::B1_TIMER_TWO] = timer_two_source_i;
        src_level[BW + posted_irq_pkg::B1_TIMER_ONE] = timer_one_source_i;
    end

    // sources come from other blocks and pins, so each is synchronised first
    source_event_sync #(
        .WIDTH(posted_irq_pkg::NUM_SOURCES)
    ) u_source_event_sync (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .level_i(src_level),
        .pulse_o(src_pulse)
    );

    assign event0 = src_pulse[BW-1:0];
    assign event1 = src_pulse[2*BW-1:BW];

    // address decode
    always_comb begin
        sel_bank0 = 1'b0;
        sel_bank1 = 1'b0;
        sel_control = 1'b0;
        sel_irq_status = 1'b0;
        sel_irq_mask = 1'b0;
        if (avs_address_i == posted_irq_pkg::ADDR_CLEAR_BANK0) begin
            sel_bank0 = 1'b1;
        end else if (avs_address_i == posted_irq_pkg::ADDR_CLEAR_BANK1) begin
            sel_bank1 = 1'b1;
        end else if (avs_address_i == posted_irq_pkg::ADDR_CONTROL) begin
            sel_control = 1'b1;
        end else if (avs_address_i == posted_irq_pkg::ADDR_IRQ_STATUS) begin
            sel_irq_status = 1'b1;
        end else if (avs_address_i == posted_irq_pkg::ADDR_IRQ_MASK) begin
            sel_irq_mask = 1'b1;
        end
    end

    // read mux; unmapped reads return zero
    always_comb begin
        read_value = posted_irq_pkg::READ_UNMAPPED;
        if (sel_bank0) begin
            read_value[BW-1:0] = interrupt_clear_bank0;
        end else if (sel_bank1) begin
            read_value[BW-1:0] = interrupt_clear_bank1;
        end else if (sel_control) begin
            read_value[posted_irq_pkg::CTRL_SW_ENABLE_BIT] = software_interrupt_enable;
        end else if (sel_irq_status) begin
            read_value[IW-1:0] = irq_status;
        end else if (sel_irq_mask) begin
            read_value[IW-1:0] = irq_mask;
        end
    end

    // one wait cycle per access; the edge that sees waitrequest low commits
    always_comb begin
        next_bus_state = bus_state;
        case (bus_state)
            posted_irq_pkg::BUS_IDLE: begin
                if (avs_read_i || avs_write_i) begin
                    next_bus_state = posted_irq_pkg::BUS_ACK;
                end
            end
            posted_irq_pkg::BUS_ACK: begin
                next_bus_state = posted_irq_pkg::BUS_IDLE;
            end
            default: begin
                next_bus_state = posted_irq_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            bus_state <= posted_irq_pkg::BUS_IDLE;
            avs_waitrequest_o <= 1'b1;
        end else begin
            bus_state <= next_bus_state;
            avs_waitrequest_o <= (next_bus_state != posted_irq_pkg::BUS_ACK);
        end
    end

    // data is latched while waitrequest is still high so it stands when it drops
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            avs_readdata_o <= posted_irq_pkg::READ_UNMAPPED;
        end else if (bus_state == posted_irq_pkg::BUS_IDLE && avs_read_i) begin
            avs_readdata_o <= read_value;
        end
    end

    assign taken = (bus_state == posted_irq_pkg::BUS_ACK) && (avs_read_i || avs_write_i);
    // all registers sit in byte lane 0; other lanes are ignored
    assign wr_lane0 = taken && avs_write_i && avs_byteenable_i[0];
    assign wbyte = avs_writedata_i[BW-1:0];
    assign wr_bank0 = wr_lane0 && sel_bank0;
    assign wr_bank1 = wr_lane0 && sel_bank1;

    // post: source events, plus ones written while software enable is set
    assign set0 = event0 | ({BW{wr_bank0 && software_interrupt_enable}} & wbyte);
    assign set1 = event1 | ({BW{wr_bank1 && software_interrupt_enable}} & wbyte);
    // clear: only zeros written while software enable is clear
    assign clr0 = {BW{wr_bank0 && !software_interrupt_enable}} & ~wbyte;
    assign clr1 = {BW{wr_bank1 && !software_interrupt_enable}} & ~wbyte;

    // per bit, so other positions are untouched; clearing zero stays zero unless that source fires in the same cycle
    assign next_bank0 = (interrupt_clear_bank0 & ~clr0) | set0;
    assign next_bank1 = (interrupt_clear_bank1 & ~clr1) | set1;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            interrupt_clear_bank0 <= posted_irq_pkg::RESET_CLEAR_BANK;
            interrupt_clear_bank1 <= posted_irq_pkg::RESET_CLEAR_BANK;
        end else begin
            interrupt_clear_bank0 <= next_bank0;
            interrupt_clear_bank1 <= next_bank1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            software_interrupt_enable <= posted_irq_pkg::RESET_SW_ENABLE;
        end else if (wr_lane0 && sel_control) begin
            software_interrupt_enable <= wbyte[posted_irq_pkg::CTRL_SW_ENABLE_BIT];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            irq_mask <= posted_irq_pkg::RESET_IRQ_MASK;
        end else if (wr_lane0 && sel_irq_mask) begin
            irq_mask <= wbyte[IW-1:0];
        end
    end

    // sticky events for the interrupt line
    always_comb begin
        irq_event = '0;
        irq_event[posted_irq_pkg::IRQ_BANK0_EVENT] = |event0;
        irq_event[posted_irq_pkg::IRQ_BANK1_EVENT] = |event1;
        irq_event[posted_irq_pkg::IRQ_SW_POST] = |(set0 & ~event0) | |(set1 & ~event1);
        // a clear that lost to a same-cycle event
        irq_event[posted_irq_pkg::IRQ_CLEAR_LOST] = |(clr0 & event0) | |(clr1 & event1);
    end

    // write one to clear; a new event in the same cycle wins
    always_comb begin
        next_irq_status = irq_status;
        if (wr_lane0 && sel_irq_status) begin
            next_irq_status = irq_status & ~wbyte[IW-1:0];
        end
        next_irq_status = next_irq_status | irq_event;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            irq_status <= posted_irq_pkg::RESET_IRQ_STATUS;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    // registered outputs lag the state by one cycle
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            irq_o <= 1'b0;
            posted_bank0_o <= posted_irq_pkg::RESET_CLEAR_BANK;
            posted_bank1_o <= posted_irq_pkg::RESET_CLEAR_BANK;
            software_interrupt_enable_o <= posted_irq_pkg::RESET_SW_ENABLE;
        end else begin
            irq_o <= |(irq_status & irq_mask);
            posted_bank0_o <= interrupt_clear_bank0;
            posted_bank1_o <= interrupt_clear_bank1;
            software_interrupt_enable_o <= software_interrupt_enable;
        end
    end

endmodule
`default_nettype wire

// >>> verif/irq_source_model.sv
// peripheral event lines that feed the interrupt controller
`timescale 1ns/10ps
`default_nettype none
module irq_source_model (
    input wire logic clk_sys_i,
    input wire logic [15:0] fire_i,
    output logic [15:0] line_o
);
    logic [15:0] fire_q = 16'h0000;
    logic [15:0] hold = 16'h0000;
    // a fire pulse gives two high cycles then low, so exactly one rising edge per event
    always @(posedge clk_sys_i) begin
        fire_q <= fire_i;
        hold <= fire_q;
    end
    assign line_o = fire_q | hold;
endmodule
`default_nettype wire

// >>> verif/posted_irq_checker_sva.sv
// checker for bus timing and posted state of the interrupt clear registers
`timescale 1ns/10ps
`default_nettype none
module posted_irq_checker (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [posted_irq_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [posted_irq_pkg::DATA_W-1:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [posted_irq_pkg::DATA_W-1:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic [posted_irq_pkg::BANK_W-1:0] posted_bank0_o,
    input wire logic [posted_irq_pkg::BANK_W-1:0] posted_bank1_o,
    input wire logic software_interrupt_enable_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    wire logic rd_taken = avs_read_i && avs_waitrequest_o;
    wire logic taken = (avs_read_i || avs_write_i) && avs_waitrequest_o;
    wire logic wr_lo = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
    wire logic wr_b0 = wr_lo && avs_address_i == posted_irq_pkg::ADDR_CLEAR_BANK0;
    wire logic wr_b1 = wr_lo && avs_address_i == posted_irq_pkg::ADDR_CLEAR_BANK1;
    wire logic mapped = avs_address_i inside {posted_irq_pkg::ADDR_CLEAR_BANK0,
        posted_irq_pkg::ADDR_CLEAR_BANK1, posted_irq_pkg::ADDR_CONTROL,
        posted_irq_pkg::ADDR_IRQ_STATUS, posted_irq_pkg::ADDR_IRQ_MASK};

    wait_one_a: assert property (taken |=> !avs_waitrequest_o)
        else $error("request not answered after one wait cycle");
    wait_short_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    wait_idle_a: assert property (!taken && avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest dropped with no request");
    rd_bank0_a: assert property (rd_taken && avs_address_i == posted_irq_pkg::ADDR_CLEAR_BANK0
        |=> avs_readdata_o == {24'h000000, posted_bank0_o})
        else $error("bank0 read differs from posted state");
    rd_bank1_a: assert property (rd_taken && avs_address_i == posted_irq_pkg::ADDR_CLEAR_BANK1
        |=> avs_readdata_o == {24'h000000, posted_bank1_o})
        else $error("bank1 read differs from posted state");
    unmapped_rd_a: assert property (rd_taken && !mapped |=> avs_readdata_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    // a posting may only drop two cycles after a clearing write with zero in that bit
    clear_b0_a: assert property (|($past(posted_bank0_o) & ~posted_bank0_o) |->
        $past(wr_b0 && !software_interrupt_enable_o, 2) &&
        ($past(posted_bank0_o) & ~posted_bank0_o & $past(avs_writedata_i[7:0], 2)) == 8'h00)
        else $error("bank0 posting lost without a clearing write");
    clear_b1_a: assert property (|($past(posted_bank1_o) & ~posted_bank1_o) |->
        $past(wr_b1 && !software_interrupt_enable_o, 2) &&
        ($past(posted_bank1_o) & ~posted_bank1_o & $past(avs_writedata_i[7:0], 2)) == 8'h00)
        else $error("bank1 posting lost without a clearing write");
    sw_post_a: assert property (wr_b1 && software_interrupt_enable_o |-> ##2
        (posted_bank1_o & $past(avs_writedata_i[7:0], 2)) == $past(avs_writedata_i[7:0], 2))
        else $error("software post did not set bank1 bits");
    sw_post_b0_a: assert property (wr_b0 && software_interrupt_enable_o |-> ##2
        (posted_bank0_o & $past(avs_writedata_i[7:0], 2)) == $past(avs_writedata_i[7:0], 2))
        else $error("software post did not set bank0 bits");

    cover property (rd_taken ##1 !avs_waitrequest_o);
    cover property (wr_b1 && software_interrupt_enable_o);
    cover property ($rose(irq_o));
endmodule
bind posted_interrupt_clear_regs posted_irq_checker u_chk (.clk_sys_i, .rst_n_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
    .avs_waitrequest_o, .posted_bank0_o, .posted_bank1_o, .software_interrupt_enable_o, .irq_o);
`default_nettype wire

// >>> verif/posted_interrupt_clear_regs_tb.sv
// self-checking bench for the posted interrupt clear registers
`timescale 1ns/10ps
`default_nettype none
module posted_interrupt_clear_regs_tb;
    localparam logic [9:0] a_ctrl = posted_irq_pkg::ADDR_CONTROL;
    localparam logic [9:0] a_stat = posted_irq_pkg::ADDR_IRQ_STATUS;
    localparam logic [9:0] a_mask = posted_irq_pkg::ADDR_IRQ_MASK;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [9:0] avs_address_i = 10'h000;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0000_0000;
    logic [3:0] avs_byteenable_i = 4'h0;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic [7:0] posted_bank0_o;
    logic [7:0] posted_bank1_o;
    logic software_interrupt_enable_o;
    logic irq_o;
    logic [15:0] fire = 16'h0000;
    logic [15:0] src;
    logic [31:0] got;
    logic [31:0] rnd;
    logic [7:0] exp_bank [2];
    integer seed = 32'h588105a2;
    int err_total = 0;
    int cmp_count = 0;

    always #4 clk_sys_i = ~clk_sys_i;

    irq_source_model u_src (.clk_sys_i, .fire_i(fire), .line_o(src));
    posted_interrupt_clear_regs u_dut (
        .clk_sys_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
        .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
        .serial_bus_event_i(src[7]), .sleep_timer_event_i(src[6]), .spi_event_i(src[5]),
        .gpio_event_i(src[4]), .general_timer_source_i(src[3]), .touch_sense_source_i(src[2]),
        .analog_event_i(src[1]), .supply_monitor_event_i(src[0]),
        .usb_ep3_event_i(src[15]), .usb_ep2_event_i(src[14]), .usb_ep1_event_i(src[13]),
        .usb_ep0_event_i(src[12]), .usb_frame_start_event_i(src[11]),
        .usb_bus_reset_event_i(src[10]), .timer_two_source_i(src[9]),
        .timer_one_source_i(src[8]), .posted_bank0_o, .posted_bank1_o,
        .software_interrupt_enable_o, .irq_o
    );

    task automatic print_verdict();
        if (err_total == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check_word(input string name, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, e, s);
        end
    endtask

    task automatic check_bit(input string name, input logic e, input logic s);
        cmp_count++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH %s expected %b seen %b", name, e, s);
        end
    endtask

    // one access; one idle edge after release so the next call never re-drives in this step
    task automatic bus_xfer(input logic wr, input logic [9:0] a, input logic [31:0] wd,
                            input logic [3:0] bev);
        int n = 0;
        avs_read_i <= !wr;
        avs_write_i <= wr;
        avs_address_i <= a;
        avs_writedata_i <= wd;
        avs_byteenable_i <= bev;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 20);
        got = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        if (avs_waitrequest_o !== 1'b0) begin
            err_total++;
            $display("MISMATCH waitrequest expected 0 seen %b", avs_waitrequest_o);
            print_verdict();
        end else begin
            @(posedge clk_sys_i);
        end
    endtask

    task automatic check_reg(input logic [9:0] a, input logic [31:0] e);
        bus_xfer(1'b0, a, 32'h0000_0000, 4'hf);
        check_word($sformatf("register %h", a), e, got);
    endtask

    function automatic logic [9:0] bank_addr(input int k);
        return k[0] ? posted_irq_pkg::ADDR_CLEAR_BANK1 : posted_irq_pkg::ADDR_CLEAR_BANK0;
    endfunction

    function automatic logic [7:0] after_write(input logic [7:0] old, input logic [7:0] wd,
                                               input logic en);
        return en ? (old | wd) : (old & wd);
    endfunction

    initial begin
        int k;
        int e;
        exp_bank = '{8'h00, 8'h00};
        // synchronous reset clears every flop, sync chain included, on each edge
        repeat (2) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        @(posedge clk_sys_i);
        bus_xfer(1'b1, 10'h000, 32'hffff_ffff, 4'hf);
        foreach (exp_bank[i]) begin
            check_reg(bank_addr(i), 32'h0000_0000);
        end
        check_reg(a_ctrl, 32'h0000_0000);
        check_reg(a_mask, 32'h0000_0000);
        check_reg(10'h000, 32'h0000_0000);
        for (k = 0; k < 16; k++) begin
            fire <= 16'h0001 << k;
            @(posedge clk_sys_i);
            fire <= 16'h0000;
            repeat (8) @(posedge clk_sys_i);
            exp_bank[k / 8][k % 8] = 1'b1;
            check_reg(bank_addr(k / 8), {24'h000000, exp_bank[k / 8]});
        end
        check_reg(a_stat, 32'h0000_0003);
        bus_xfer(1'b1, a_mask, 32'h0000_0001, 4'hf);
        repeat (3) @(posedge clk_sys_i);
        check_bit("irq", 1'b1, irq_o);
        bus_xfer(1'b1, a_mask, 32'h0000_0000, 4'hf);
        repeat (3) @(posedge clk_sys_i);
        check_bit("irq", 1'b0, irq_o);
        bus_xfer(1'b1, a_stat, 32'h0000_000f, 4'hf);
        check_reg(a_stat, 32'h0000_0000);
        // lane 0 disabled: the clear must not land
        bus_xfer(1'b1, bank_addr(1), 32'h0000_0000, 4'he);
        check_reg(bank_addr(1), 32'h0000_00ff);
        for (e = 0; e < 2; e++) begin
            bus_xfer(1'b1, a_ctrl, {31'h0, e[0]}, 4'h1);
            check_reg(a_ctrl, {31'h0, e[0]});
            check_bit("enable", e[0], software_interrupt_enable_o);
            for (k = 0; k < 10; k++) begin
                rnd = $random(seed);
                bus_xfer(1'b1, bank_addr(k), rnd, 4'hf);
                exp_bank[k % 2] = after_write(exp_bank[k % 2], rnd[7:0], e[0]);
                check_reg(bank_addr(k), {24'h000000, exp_bank[k % 2]});
            end
        end
        check_reg(a_stat, 32'h0000_0004);
        bus_xfer(1'b1, a_ctrl, 32'h0000_0000, 4'h1);
        for (k = 0; k < 2; k++) begin
            bus_xfer(1'b1, bank_addr(k), 32'h0000_0000, 4'h1);
            check_reg(bank_addr(k), 32'h0000_0000);
        end
        bus_xfer(1'b1, a_stat, 32'h0000_000f, 4'hf);
        // event lands on the same edge as the clearing write
        fire <= 16'h0010;
        @(posedge clk_sys_i);
        fire <= 16'h0000;
        repeat (2) @(posedge clk_sys_i);
        bus_xfer(1'b1, bank_addr(0), 32'h0000_0000, 4'h1);
        check_reg(bank_addr(0), 32'h0000_0010);
        check_reg(a_stat, 32'h0000_0009);
        print_verdict();
    end
endmodule
`default_nettype wire
